// ==== hdl/dacdr_top.v ====
// data holding, output and status registers of one converter channel
// ============================================================
//
// Added by the designer: register access over AXI4-Lite.
module dacdr_top #(
  parameter SAMPLE_W = 12
) (
  input  wire                clk,
  input  wire                arst_n,
  input  wire                ce,
  input  wire [7:0]          s_awaddr,
  input  wire                s_awvalid,
  output wire                s_awready,
  input  wire [31:0]         s_wdata,
  input  wire [3:0]          s_wstrb,
  input  wire                s_wvalid,
  output wire                s_wready,
  output wire [1:0]          s_bresp,
  output wire                s_bvalid,
  input  wire                s_bready,
  input  wire [7:0]          s_araddr,
  input  wire                s_arvalid,
  output wire                s_arready,
  output wire [31:0]         s_rdata,
  output wire [1:0]          s_rresp,
  output wire                s_rvalid,
  input  wire                s_rready,
  input  wire                ext_trig,
  output reg                 dma_req,
  output reg                 underrun_irq,
  output reg  [SAMPLE_W-1:0] converted_sample
);
  `include "dacdr_regs.vh"

  reg                 ctrl_trig_en;
  reg  [1:0]          ctrl_trig_sel;
  reg                 dma_request_enable;
  reg                 dma_underrun_irq_enable;
  reg                 sw_trig;
  reg                 dma_underrun_flag;
  reg  [SAMPLE_W-1:0] pending_sample_field;
  reg                 hold_wr_d;
  reg  [SAMPLE_W-1:0] next_pending;
  reg                 hold_wr;
  reg  [31:0]         rd_data;
  reg                 rd_hit;
  reg                 wr_hit;
  reg                 conv_event;
  reg                 next_underrun;
  reg                 next_dma_en;
  reg                 next_irq_en;
  wire                wr_en;
  wire                rd_en;
  wire [7:0]          wr_addr;
  wire [31:0]         wr_data;

  // ============================================================
  // bus front end
  dacdr_axil u_axil (
    .clk       (clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .wr_hit    (wr_hit),
    .rd_en     (rd_en),
    .rd_data   (rd_data),
    .rd_hit    (rd_hit)
  );

  // ============================================================
  // decode and pending sample formatting
  // address hit kept apart from the formatter, so wr_en never feeds back into its own source
  always @* begin
    wr_hit = 1'b1;
    case (wr_addr)
      `DACDR_CTRL_OFS, `DACDR_SWTRIG_OFS, `DACDR_STAT_OFS : wr_hit = 1'b1;
      `DACDR_R12_OFS, `DACDR_L12_OFS, `DACDR_R8_OFS      : wr_hit = 1'b1;
      `DACDR_OUT_OFS : wr_hit = 1'b1;  // accepted, output field is read only
      default : wr_hit = 1'b0;
    endcase
  end

  always @* begin
    hold_wr      = 1'b0;
    next_pending = pending_sample_field;
    case (wr_addr)
      `DACDR_R12_OFS : begin
        hold_wr      = wr_en;
        next_pending = wr_data[11:0];
      end
      `DACDR_L12_OFS : begin
        hold_wr      = wr_en;
        next_pending = wr_data[15:4];
      end
      `DACDR_R8_OFS : begin
        hold_wr      = wr_en;
        next_pending = {wr_data[7:0], 4'h0};
      end
      default : next_pending = pending_sample_field;
    endcase
  end

  always @* begin
    rd_hit  = 1'b1;
    rd_data = 32'h00000000;  // reserved bits read zero
    case (s_araddr)
      `DACDR_CTRL_OFS : begin
        rd_data[`DACDR_TRIG_EN_BIT]                         = ctrl_trig_en;
        rd_data[`DACDR_TRIG_SEL_HI:`DACDR_TRIG_SEL_LO]      = ctrl_trig_sel;
        rd_data[`DACDR_DMA_EN_BIT]                          = dma_request_enable;
        rd_data[`DACDR_IRQ_EN_BIT]                          = dma_underrun_irq_enable;
      end
      `DACDR_SWTRIG_OFS : rd_data[`DACDR_SWTRIG_BIT] = sw_trig;
      `DACDR_R12_OFS : rd_data[11:0] = pending_sample_field;
      `DACDR_L12_OFS : rd_data[15:4] = pending_sample_field;
      `DACDR_R8_OFS  : rd_data[7:0]  = pending_sample_field[11:4];
      `DACDR_OUT_OFS : rd_data[11:0] = converted_sample;
      `DACDR_STAT_OFS : rd_data[`DACDR_UNDERRUN_BIT] = dma_underrun_flag;
      default : rd_hit = 1'b0;
    endcase
  end

  // ============================================================
  // conversion event and underrun detection
  always @* begin
    if (!ctrl_trig_en) begin
      conv_event = hold_wr_d;
    end else begin
      case (ctrl_trig_sel)
        `DACDR_TSEL_EXT : conv_event = ext_trig;
        `DACDR_TSEL_SW  : conv_event = sw_trig;
        default         : conv_event = 1'b0;
      endcase
    end
    // enables as they will stand after this edge, so no output outlives a disable
    next_dma_en = dma_request_enable;
    next_irq_en = dma_underrun_irq_enable;
    if (wr_en && wr_addr == `DACDR_CTRL_OFS) begin
      next_dma_en = wr_data[`DACDR_DMA_EN_BIT];
      next_irq_en = wr_data[`DACDR_IRQ_EN_BIT];
    end
    next_underrun = dma_underrun_flag;
    // a write of one clears, but a fresh underrun in that cycle wins
    if (wr_en && wr_addr == `DACDR_STAT_OFS && wr_data[`DACDR_UNDERRUN_BIT])
      next_underrun = 1'b0;
    // trigger while the previous request is still unserved: data came too slow
    if (conv_event && ctrl_trig_en && dma_request_enable && dma_req)
      next_underrun = 1'b1;
  end

  // ============================================================
  // registers
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_trig_en            <= 1'b0;
      ctrl_trig_sel           <= 2'h0;
      dma_request_enable      <= 1'b0;
      dma_underrun_irq_enable <= 1'b0;
      sw_trig                 <= 1'b0;
      dma_underrun_flag       <= 1'b0;
      pending_sample_field    <= 12'h000;
      converted_sample        <= 12'h000;
      hold_wr_d               <= 1'b0;
      dma_req                 <= 1'b0;
      underrun_irq            <= 1'b0;
    end else if (ce) begin
      if (wr_en && wr_addr == `DACDR_CTRL_OFS) begin
        ctrl_trig_en            <= wr_data[`DACDR_TRIG_EN_BIT];
        ctrl_trig_sel           <= wr_data[`DACDR_TRIG_SEL_HI:`DACDR_TRIG_SEL_LO];
        dma_request_enable      <= wr_data[`DACDR_DMA_EN_BIT];
        dma_underrun_irq_enable <= wr_data[`DACDR_IRQ_EN_BIT];
      end
      // software trigger lasts one cycle, cleared by hardware
      sw_trig <= wr_en && wr_addr == `DACDR_SWTRIG_OFS && wr_data[`DACDR_SWTRIG_BIT];
      if (hold_wr)
        pending_sample_field <= next_pending;
      // delayed so the untriggered conversion picks up the freshly stored sample
      hold_wr_d <= hold_wr;
      if (conv_event)
        converted_sample <= pending_sample_field;
      // new data written serves the request; a new trigger asks again
      if (conv_event && ctrl_trig_en && next_dma_en)
        dma_req <= 1'b1;
      else if (hold_wr || !next_dma_en)
        dma_req <= 1'b0;
      // output still takes the stale sample on an underrun; the flag and, when enabled, underrun_irq tell software
      dma_underrun_flag <= next_underrun;
      // irq follows flag and enable as both stand after this edge
      underrun_irq      <= next_underrun & next_irq_en;
    end
  end
endmodule

// ==== hdl/dacdr_regs.vh ====
// register map, field positions and reset values of the converter channel data registers
`ifndef DACDR_REGS_VH
`define DACDR_REGS_VH
// ============================================================
// offsets
`define DACDR_CTRL_OFS      8'h00
`define DACDR_SWTRIG_OFS    8'h04
`define DACDR_R12_OFS       8'h08
`define DACDR_L12_OFS       8'h0C
`define DACDR_R8_OFS        8'h10
`define DACDR_OUT_OFS       8'h14
`define DACDR_STAT_OFS      8'h18
// ============================================================
// field positions
`define DACDR_TRIG_EN_BIT   2
`define DACDR_TRIG_SEL_LO   3
`define DACDR_TRIG_SEL_HI   4
`define DACDR_DMA_EN_BIT    12
`define DACDR_IRQ_EN_BIT    13
`define DACDR_UNDERRUN_BIT  13
`define DACDR_SWTRIG_BIT    0
`define DACDR_TSEL_EXT      2'h0
`define DACDR_TSEL_SW       2'h1
// ============================================================
// reset values and bus answers
`define DACDR_RESET_VAL     32'h00000000
`define DACDR_RESP_OKAY     2'h0
`define DACDR_RESP_SLVERR   2'h2
`define DACDR_FULL_STRB     4'hF
`endif

// ==== hdl/dacdr_axil.v ====
// axi4-lite slave front end: one write and one read in flight, registered answers
module dacdr_axil (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        ce,
  input  wire [7:0]  s_awaddr,
  input  wire        s_awvalid,
  output reg         s_awready,
  input  wire [31:0] s_wdata,
  input  wire [3:0]  s_wstrb,
  input  wire        s_wvalid,
  output reg         s_wready,
  output reg  [1:0]  s_bresp,
  output reg         s_bvalid,
  input  wire        s_bready,
  input  wire [7:0]  s_araddr,
  input  wire        s_arvalid,
  output reg         s_arready,
  output reg  [31:0] s_rdata,
  output reg  [1:0]  s_rresp,
  output reg         s_rvalid,
  input  wire        s_rready,
  output wire        wr_en,
  output reg  [7:0]  wr_addr,
  output reg  [31:0] wr_data,
  input  wire        wr_hit,
  output wire        rd_en,
  input  wire [31:0] rd_data,
  input  wire        rd_hit
);
  `include "dacdr_regs.vh"

  reg       aw_held;
  reg       w_held;
  reg [3:0] wr_strb;
  wire      full_word;

  // partial words are refused: byte lanes would tear the 12-bit sample
  assign full_word = (wr_strb == `DACDR_FULL_STRB);
  assign wr_en     = aw_held & w_held & ~s_bvalid & wr_hit & full_word;
  assign rd_en     = s_arvalid & s_arready;

  // ============================================================
  // write channels
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 32'h00000000;
      wr_strb   <= 4'h0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= 2'h0;
    end else if (ce) begin
      s_awready <= ~aw_held & ~(s_awvalid & s_awready) & ~s_bvalid;
      s_wready  <= ~w_held & ~(s_wvalid & s_wready) & ~s_bvalid;
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held  <= 1'b1;
        wr_data <= s_wdata;
        wr_strb <= s_wstrb;
      end
      if (aw_held && w_held && !s_bvalid) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp  <= (wr_hit && full_word) ? `DACDR_RESP_OKAY : `DACDR_RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // ============================================================
  // read channels
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h00000000;
      s_rresp   <= 2'h0;
    end else if (ce) begin
      s_arready <= ~s_rvalid & ~(s_arvalid & s_arready);
      if (rd_en) begin
        s_rvalid <= 1'b1;
        s_rdata  <= rd_data;
        s_rresp  <= rd_hit ? `DACDR_RESP_OKAY : `DACDR_RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ==== dv/dacdr_top_assertions.sv ====
// assertion checker on the register bus and outputs of the converter channel
`include "dacdr_regs.vh"
module dacdr_top_assertions (
  input logic        clk,
  input logic        arst_n,
  input logic        s_awready,
  input logic        s_wready,
  input logic        s_bvalid,
  input logic        s_bready,
  input logic        s_arvalid,
  input logic        s_arready,
  input logic [7:0]  s_araddr,
  input logic        s_rvalid,
  input logic        s_rready,
  input logic [31:0] s_rdata,
  input logic [1:0]  s_rresp,
  input logic        dma_req,
  input logic        underrun_irq,
  input logic [11:0] converted_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire rd_go = s_arvalid && s_arready;
  // ============================================================
  // handshakes
  property p_ar_answer; rd_go |=> s_rvalid; endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read not answered");
  property p_r_hold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_hold; s_bvalid && !s_bready |=> s_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_busy; s_bvalid |-> !s_awready && !s_wready; endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken while busy");
  property p_r_busy; s_rvalid |-> !s_arready; endproperty
  a_r_busy: assert property (p_r_busy) else $error("read taken while busy");
  // ============================================================
  // read values
  property p_out_rd;
    rd_go && s_araddr == `DACDR_OUT_OFS |=> s_rdata == {20'h0, $past(converted_sample)};
  endproperty
  a_out_rd: assert property (p_out_rd) else $error("output read mismatch");
  property p_stat_rsv;
    rd_go && s_araddr == `DACDR_STAT_OFS |=> s_rdata[31:14] == 0 && s_rdata[12:0] == 0;
  endproperty
  a_stat_rsv: assert property (p_stat_rsv) else $error("status reserved bits set");
  property p_unmap;
    rd_go && s_araddr > `DACDR_STAT_OFS |=> s_rresp == `DACDR_RESP_SLVERR && s_rdata == 0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  c_unmap: cover property (rd_go && s_araddr > `DACDR_STAT_OFS);
  c_irq: cover property ($rose(underrun_irq));
  c_dma: cover property ($rose(dma_req));
endmodule
bind dacdr_top dacdr_top_assertions dacdr_top_assertions_inst (.clk, .arst_n, .s_awready, .s_wready,
  .s_bvalid, .s_bready, .s_arvalid, .s_arready, .s_araddr, .s_rvalid, .s_rready, .s_rdata,
  .s_rresp, .dma_req, .underrun_irq, .converted_sample);

// ==== dv/dacdr_axi_master.sv ====
// bus master model standing in for the processor on the register bus
module dacdr_axi_master (
  input  logic        clk,
  output logic [7:0]  s_awaddr,
  output logic        s_awvalid,
  input  logic        s_awready,
  output logic [31:0] s_wdata,
  output logic [3:0]  s_wstrb,
  output logic        s_wvalid,
  input  logic        s_wready,
  input  logic [1:0]  s_bresp,
  input  logic        s_bvalid,
  output logic        s_bready,
  output logic [7:0]  s_araddr,
  output logic        s_arvalid,
  input  logic        s_arready,
  input  logic [31:0] s_rdata,
  input  logic [1:0]  s_rresp,
  input  logic        s_rvalid,
  output logic        s_rready,
  output logic        hung
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, hung} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
  end
  // payload is inverted once taken so a stale value is never mistaken for live data
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, input int slow,
                    output logic [1:0] r);
    bit go;
    go = 1'b1;
    r = 2'h3;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= st;
    {s_awvalid, s_wvalid, s_bready} <= {2'b11, slow == 0};
    for (int n = 0; n < 64 && go; n++) begin
      @(posedge clk);
      if (s_awready) {s_awvalid, s_awaddr} <= {1'b0, ~a};
      if (s_wready) {s_wvalid, s_wdata} <= {1'b0, ~d};
      if (s_bvalid && s_bready) begin
        r = s_bresp;
        go = 1'b0;
      end
      s_bready <= go && n + 1 >= slow;
    end
    if (go) hung <= 1'b1;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input int slow, output logic [31:0] d, output logic [1:0] r);
    bit go;
    go = 1'b1;
    {d, r} = '1;
    s_araddr <= a;
    {s_arvalid, s_rready} <= {1'b1, slow == 0};
    for (int n = 0; n < 64 && go; n++) begin
      @(posedge clk);
      if (s_arready) {s_arvalid, s_araddr} <= {1'b0, ~a};
      if (s_rvalid && s_rready) begin
        {d, r} = {s_rdata, s_rresp};
        go = 1'b0;
      end
      s_rready <= go && n + 1 >= slow;
    end
    if (go) hung <= 1'b1;
    @(posedge clk);
  endtask
endmodule

// ==== dv/tb_dacdr_top.sv ====
// self-checking bench of the converter channel data registers
module tb_dacdr_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = 2'h0;
  localparam logic [1:0] SE = 2'h2;
  logic        clk, arst_n, ce, ext_trig, hung, dma_req, underrun_irq;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd_v;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic [11:0] converted_sample;
  int          fails, checks, pend, outv, flag, v, i;
  dacdr_top dacdr_top_inst (.clk, .arst_n, .ce, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .ext_trig, .dma_req, .underrun_irq, .converted_sample);
  dacdr_axi_master dacdr_axi_master_inst (.clk, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .hung);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic conclude;
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    dacdr_axi_master_inst.wr(a, d, 4'hF, $urandom_range(3), rsp);
    chk(32'(rsp), 32'(e));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    dacdr_axi_master_inst.rd(a, $urandom_range(3), rd_v, rsp);
    chk(rd_v, e);
    chk(32'(rsp), 32'(er));
  endtask
  task automatic pulse;
    ext_trig <= 1'b1;
    @(posedge clk);
    ext_trig <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk) if (hung === 1'b1) begin
    fails++;
    conclude();
  end
  // ============================================================
  // main sequence
  initial begin
    {fails, checks, pend, outv, flag} = '0;
    {ce, ext_trig, arst_n} = 3'b100;
    void'($urandom(32'hd33be13a));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 7; i++) rd(8'(4 * i), 0, OK);
    chk({dma_req, underrun_irq, converted_sample}, 0);
    for (i = 0; i < 3; i++) begin
      v = $urandom_range(4095);
      wr(8'(8 + 4 * i), i == 0 ? v : (i == 1 ? v << 4 : v >> 4), OK);
      pend = (i == 2) ? (v & 32'hFF0) : v;
      outv = pend;
      repeat (2) @(posedge clk);
      chk(32'(converted_sample), outv);
      rd(8'h14, outv, OK);
      rd(8'h08, pend, OK);
      rd(8'h0C, pend << 4, OK);
      rd(8'h10, pend >> 4, OK);
    end
    wr(8'h14, 32'h0000_0ABC, OK);
    dacdr_axi_master_inst.wr(8'h08, 32'h0000_0123, 4'h3, 0, rsp);
    chk(32'(rsp), 32'(SE));
    rd(8'h08, pend, OK);
    wr(8'h20, 32'h0000_0001, SE);
    rd(8'h20, 0, SE);
    rd(8'h14, outv, OK);
    wr(8'h00, 32'h0000_0004, OK);
    pend = $urandom_range(4095);
    wr(8'h08, pend, OK);
    repeat (3) @(posedge clk);
    chk(32'(converted_sample), outv);
    pulse();
    outv = pend;
    chk(32'(converted_sample), outv);
    wr(8'h00, 32'h0000_000C, OK);
    pend = $urandom_range(4095);
    wr(8'h08, pend, OK);
    wr(8'h04, 32'h0000_0001, OK);
    outv = pend;
    repeat (2) @(posedge clk);
    chk(32'(converted_sample), outv);
    wr(8'h00, 32'h0000_1004, OK);
    pulse();
    chk(32'(dma_req), 1);
    pulse();
    flag = 1;
    rd(8'h18, flag << 13, OK);
    chk(32'(underrun_irq), 0);
    wr(8'h00, 32'h0000_3004, OK);
    chk(32'(underrun_irq), 1);
    wr(8'h18, 32'h0000_0000, OK);
    rd(8'h18, flag << 13, OK);
    wr(8'h18, 32'h0000_2000, OK);
    flag = 0;
    rd(8'h18, flag << 13, OK);
    chk(32'(underrun_irq), 0);
    wr(8'h08, pend, OK);
    chk(32'(dma_req), 0);
    wr(8'h00, 32'h0000_0004, OK);
    pulse();
    pulse();
    chk(32'(dma_req), 0);
    rd(8'h18, flag << 13, OK);
    chk(32'(converted_sample), outv);
    pend = $urandom_range(4095);
    wr(8'h0C, pend << 4, OK);
    ce <= 1'b0;
    pulse();
    chk(32'(converted_sample), outv);
    ce <= 1'b1;
    pulse();
    outv = pend;
    chk(32'(converted_sample), outv);
    conclude();
  end
endmodule
